// >>> hw/acr_pkg.sv
// Package with register map, field layout and reset values for the channel trim slice
`default_nettype none
package acr_pkg;
   // Printed offsets are word indices; byte address is four times the index
   localparam logic [7:0]  IDX_THRESH_LOW        = 8'h08;
   localparam logic [7:0]  IDX_CH0_GAIN_HIGH     = 8'h0C;
   localparam logic [7:0]  IDX_CH0_GAIN_LOW      = 8'h0D;
   localparam logic [7:0]  IDX_CH1_CONFIG        = 8'h0E;
   localparam logic [7:0]  IDX_CH1_OFFSET_HIGH   = 8'h0F;
   localparam logic [7:0]  IDX_CH1_OFFSET_LOW    = 8'h10;
   localparam int          ADDR_W                = 8;

   // Field positions
   localparam int          PHASE_LSB             = 6;
   localparam int          PHASE_MSB             = 15;
   localparam int          BYPASS_BIT            = 2;
   localparam int          SEL_LSB               = 0;
   localparam int          SEL_MSB               = 1;
   localparam int          LOW_BYTE_LSB          = 8;
   localparam int          LOW_BYTE_MSB          = 15;
   localparam int          GLOBAL_DC_LSB         = 0;
   localparam int          GLOBAL_DC_MSB         = 3;

   // Writable-bit masks
   localparam logic [15:0] MASK_FULL             = 16'hFFFF;
   localparam logic [15:0] MASK_LOW_BYTE         = 16'hFF00;
   localparam logic [15:0] MASK_CONFIG           = 16'hFFC7;
   localparam logic [15:0] MASK_THRESH_LOW       = 16'hFF0F;

   // Reset values
   localparam logic [15:0] RST_GAIN_HIGH         = 16'h8000;
   localparam logic [15:0] RST_ZERO              = 16'h0000;

   // Input selector codes
   typedef enum logic [1:0] {
      ACR_SEL_NORMAL  = 2'h0,
      ACR_SEL_SHORTED = 2'h1,
      ACR_SEL_POS_DC  = 2'h2,
      ACR_SEL_NEG_DC  = 2'h3
   } acr_sel_t;

   // AXI response codes
   localparam logic [1:0]  RESP_OKAY             = 2'h0;
   localparam logic [1:0]  RESP_SLVERR           = 2'h2;
endpackage : acr_pkg
`default_nettype wire

// >>> hw/acr_trim_reg.sv
// One 16-bit trim register with write mask and byte strobes
`default_nettype none
module acr_trim_reg
   import acr_pkg::*;
#(
   parameter logic [15:0] RESET_VALUE = 16'h0000,
   parameter logic [15:0] WRITE_MASK  = 16'hFFFF
) (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   input  wire logic        wr_en,
   input  wire logic [1:0]  wr_strb,
   input  wire logic [15:0] wr_data,
   output logic      [15:0] value
);
   logic [15:0] value_reg;
   logic [15:0] lane_mask;

   assign lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & WRITE_MASK;
   assign value     = value_reg;

   always_ff @(posedge mclk) begin
      if (reset) begin
         value_reg <= RESET_VALUE;
      end else if (clk_en && wr_en) begin
         // Reserved bits stay zero
         value_reg <= (value_reg & ~lane_mask) | (wr_data & lane_mask);
      end
   end
endmodule : acr_trim_reg
`default_nettype wire

// >>> hw/acr_input_decode.sv
// Decoder of the input selector and effective DC filter enable for one channel
`default_nettype none
module acr_input_decode
   import acr_pkg::*;
(
   input  wire logic [1:0] select,
   input  wire logic       bypass,
   input  wire logic [3:0] global_setting,
   output logic            use_own_pair,
   output logic            inputs_shorted,
   output logic            test_positive,
   output logic            test_negative,
   output logic            dc_filter_active
);
   always_comb begin
      use_own_pair   = 1'b0;
      inputs_shorted = 1'b0;
      test_positive  = 1'b0;
      test_negative  = 1'b0;
      unique case (acr_sel_t'(select))
         ACR_SEL_NORMAL:  use_own_pair   = 1'b1;
         ACR_SEL_SHORTED: inputs_shorted = 1'b1;
         ACR_SEL_POS_DC:  test_positive  = 1'b1;
         ACR_SEL_NEG_DC:  test_negative  = 1'b1;
      endcase
   end

   // Zero global setting means filter off; bypass forces it off
   assign dc_filter_active = !bypass && (global_setting != 4'h0);
endmodule : acr_input_decode
`default_nettype wire

// >>> hw/acr_regs.sv
// AXI4-Lite register slice for channel 0 gain trim and channel 1 config and offset trim
// Function
// RULE1 - Gain trim is 24 bits: high word bits 23:8, low word upper byte bits 7:0.
// RULE2 - Gain trim is unsigned, spanning gain zero to just under two.
// RULE3 - Offset trim is 24-bit two's complement, split high word and low upper byte.
// RULE4 - Phase delay is 10-bit signed in config bits 15:6.
// RULE5 - Config bit 2 set disables DC filter for this channel; clear follows global.
// RULE6 - Selector bits 1:0: own pair, shorted, positive test, negative test.
// RULE7 - Word addresses 0Dh gain low, 0Eh config, 0Fh offset high, 10h offset low.
// RULE8 - Config and both offset registers reset to zero.
// RULE9 - Global DC filter setting is bits 3:0 of threshold low register.
// RULE10 - Gain high register resets to 8000h, unity gain.
// RULE11 - Reserved bits ignore writes and read as zero.
`default_nettype none
module acr_regs
   import acr_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [23:0]      ch_zero_gain_trim,
   output logic             ch_zero_gain_unity,
   output logic [23:0]      ch_one_offset_trim,
   output logic [9:0]       ch_one_phase_delay,
   output logic             ch_one_dc_filter_bypass,
   output logic [1:0]       ch_one_input_select,
   output logic [3:0]       global_dc_filter_setting,
   output logic             ch_one_use_own_pair,
   output logic             ch_one_inputs_shorted,
   output logic             ch_one_test_positive,
   output logic             ch_one_test_negative,
   output logic             ch_one_dc_filter_active
);
   ////////////////////////////////////////////////////////////////////////////////
   // Word index decode
   function automatic logic [5:0] sel_of(input logic [31:0] addr);
      logic [ADDR_W-1:0] idx;
      idx = addr[ADDR_W+1:2];
      sel_of = '0;
      if (addr[31:ADDR_W+2] == '0) begin
         sel_of[0] = (idx == IDX_THRESH_LOW);
         sel_of[1] = (idx == IDX_CH0_GAIN_HIGH);
         sel_of[2] = (idx == IDX_CH0_GAIN_LOW);      // [RULE7]
         sel_of[3] = (idx == IDX_CH1_CONFIG);        // [RULE7]
         sel_of[4] = (idx == IDX_CH1_OFFSET_HIGH);   // [RULE7]
         sel_of[5] = (idx == IDX_CH1_OFFSET_LOW);    // [RULE7]
      end
   endfunction : sel_of

   ////////////////////////////////////////////////////////////////////////////////
   // Write channel
   logic        aw_held_reg;
   logic [31:0] aw_addr_reg;
   logic        w_held_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        do_write;
   logic [5:0]  wsel;

   // Ready only while state can move, so no request is taken and then lost
   assign s_axi_awready = clk_en && !aw_held_reg && !bvalid_reg;
   assign s_axi_wready  = clk_en && !w_held_reg && !bvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign do_write      = clk_en && aw_held_reg && w_held_reg && !bvalid_reg;
   assign wsel          = sel_of(aw_addr_reg);

   always_ff @(posedge mclk) begin
      if (reset) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 32'h0000_0000;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else if (clk_en) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (do_write) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
      end else if (clk_en) begin
         if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wsel != '0) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register storage
   logic [15:0] thresh_low;
   logic [15:0] chan0_gain_trim_high;
   logic [15:0] chan0_gain_trim_low;
   logic [15:0] chan1_config;
   logic [15:0] chan1_offset_trim_high;
   logic [15:0] chan1_offset_trim_low;

   acr_trim_reg #(.RESET_VALUE(RST_ZERO), .WRITE_MASK(MASK_THRESH_LOW)) u_thresh_low ( // [RULE9]
      .mclk    (mclk),
      .reset   (reset),
      .clk_en  (clk_en),
      .wr_en   (do_write && wsel[0]),
      .wr_strb (w_strb_reg[1:0]),
      .wr_data (w_data_reg[15:0]),
      .value   (thresh_low)
   );

   acr_trim_reg #(.RESET_VALUE(RST_GAIN_HIGH), .WRITE_MASK(MASK_FULL)) u_gain_high ( // [RULE10]
      .mclk    (mclk),
      .reset   (reset),
      .clk_en  (clk_en),
      .wr_en   (do_write && wsel[1]),
      .wr_strb (w_strb_reg[1:0]),
      .wr_data (w_data_reg[15:0]),
      .value   (chan0_gain_trim_high)
   );

   acr_trim_reg #(.RESET_VALUE(RST_ZERO), .WRITE_MASK(MASK_LOW_BYTE)) u_gain_low ( // [RULE11]
      .mclk    (mclk),
      .reset   (reset),
      .clk_en  (clk_en),
      .wr_en   (do_write && wsel[2]),
      .wr_strb (w_strb_reg[1:0]),
      .wr_data (w_data_reg[15:0]),
      .value   (chan0_gain_trim_low)
   );

   acr_trim_reg #(.RESET_VALUE(RST_ZERO), .WRITE_MASK(MASK_CONFIG)) u_ch1_config ( // [RULE8] [RULE11]
      .mclk    (mclk),
      .reset   (reset),
      .clk_en  (clk_en),
      .wr_en   (do_write && wsel[3]),
      .wr_strb (w_strb_reg[1:0]),
      .wr_data (w_data_reg[15:0]),
      .value   (chan1_config)
   );

   acr_trim_reg #(.RESET_VALUE(RST_ZERO), .WRITE_MASK(MASK_FULL)) u_ofs_high ( // [RULE8]
      .mclk    (mclk),
      .reset   (reset),
      .clk_en  (clk_en),
      .wr_en   (do_write && wsel[4]),
      .wr_strb (w_strb_reg[1:0]),
      .wr_data (w_data_reg[15:0]),
      .value   (chan1_offset_trim_high)
   );

   acr_trim_reg #(.RESET_VALUE(RST_ZERO), .WRITE_MASK(MASK_LOW_BYTE)) u_ofs_low ( // [RULE8] [RULE11]
      .mclk    (mclk),
      .reset   (reset),
      .clk_en  (clk_en),
      .wr_en   (do_write && wsel[5]),
      .wr_strb (w_strb_reg[1:0]),
      .wr_data (w_data_reg[15:0]),
      .value   (chan1_offset_trim_low)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Field outputs
   assign ch_zero_gain_trim  = {chan0_gain_trim_high,
                                chan0_gain_trim_low[LOW_BYTE_MSB:LOW_BYTE_LSB]}; // [RULE1]
   // Unsigned: 800000h is unity, FFFFFFh just under two
   assign ch_zero_gain_unity = (ch_zero_gain_trim == {RST_GAIN_HIGH, 8'h00}); // [RULE2]
   assign ch_one_offset_trim = {chan1_offset_trim_high,
                                chan1_offset_trim_low[LOW_BYTE_MSB:LOW_BYTE_LSB]}; // [RULE3]
   assign ch_one_phase_delay      = chan1_config[PHASE_MSB:PHASE_LSB];   // [RULE4]
   assign ch_one_dc_filter_bypass = chan1_config[BYPASS_BIT];            // [RULE5]
   assign ch_one_input_select     = chan1_config[SEL_MSB:SEL_LSB];       // [RULE6]
   assign global_dc_filter_setting = thresh_low[GLOBAL_DC_MSB:GLOBAL_DC_LSB]; // [RULE9]

   acr_input_decode u_decode ( // [RULE5] [RULE6]
      .select           (ch_one_input_select),
      .bypass           (ch_one_dc_filter_bypass),
      .global_setting   (global_dc_filter_setting),
      .use_own_pair     (ch_one_use_own_pair),
      .inputs_shorted   (ch_one_inputs_shorted),
      .test_positive    (ch_one_test_positive),
      .test_negative    (ch_one_test_negative),
      .dc_filter_active (ch_one_dc_filter_active)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Read channel
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic [5:0]  rsel;
   logic [15:0] rword;

   assign s_axi_arready = clk_en && !rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;
   assign rsel          = sel_of(s_axi_araddr);

   always_comb begin
      rword = 16'h0000;
      if (rsel[0]) rword = thresh_low;
      if (rsel[1]) rword = chan0_gain_trim_high;
      if (rsel[2]) rword = chan0_gain_trim_low;
      if (rsel[3]) rword = chan1_config;
      if (rsel[4]) rword = chan1_offset_trim_high;
      if (rsel[5]) rword = chan1_offset_trim_low;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {16'h0000, rword}; // [RULE11]
            rresp_reg  <= (rsel != '0) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end
endmodule : acr_regs
`default_nettype wire

// >>> dv/acr_regs_sva.sv
// Assertion checker for the channel trim register slice
`default_nettype none
module acr_regs_sva
   import acr_pkg::*;
(
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic        clk_en,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [23:0] ch_zero_gain_trim,
   input wire logic        ch_zero_gain_unity,
   input wire logic [23:0] ch_one_offset_trim,
   input wire logic [9:0]  ch_one_phase_delay,
   input wire logic        ch_one_dc_filter_bypass,
   input wire logic [1:0]  ch_one_input_select,
   input wire logic [3:0]  global_dc_filter_setting,
   input wire logic        ch_one_use_own_pair,
   input wire logic        ch_one_inputs_shorted,
   input wire logic        ch_one_test_positive,
   input wire logic        ch_one_test_negative,
   input wire logic        ch_one_dc_filter_active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   ////////////////////////////////////////////////////////////////////////////////
   AST_UNITY: assert property (disable iff (reset)
      ch_zero_gain_unity == (ch_zero_gain_trim == 24'h800000)) else $error("unity flag wrong");
   AST_SEL_DEC: assert property (disable iff (reset)
      {ch_one_test_negative, ch_one_test_positive, ch_one_inputs_shorted, ch_one_use_own_pair}
      == (4'h1 << ch_one_input_select)) else $error("selector decode wrong");
   AST_DC_ACT: assert property (disable iff (reset)
      ch_one_dc_filter_active == (!ch_one_dc_filter_bypass && global_dc_filter_setting != 4'h0))
      else $error("dc filter enable wrong");
   AST_RST_VAL: assert property (reset |=> ch_zero_gain_trim == 24'h800000 &&
      ch_one_offset_trim == 24'h0 && ch_one_phase_delay == 10'h0 && ch_one_input_select == 2'h0)
      else $error("reset value wrong");
   AST_RD_LAT: assert property (disable iff (reset)
      s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid) else $error("read late");
   AST_RD_HOLD: assert property (disable iff (reset)
      s_axi_rvalid && !(s_axi_rready && clk_en) |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_RD_RSV: assert property (disable iff (reset)
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper read bits set");
   AST_WR_LAT: assert property (disable iff (reset)
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en |=> ##1 s_axi_bvalid)
      else $error("write answer late");
   COV_RD: cover property (s_axi_rvalid && s_axi_rready);
   COV_WR: cover property (s_axi_bvalid);
   COV_NEG: cover property (ch_one_test_negative);
endmodule : acr_regs_sva
`default_nettype wire

// >>> dv/acr_regs_tb_top.sv
// Self-checking bench for the channel trim register slice
`default_nettype none
module acr_regs_tb_top
   import acr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, reset, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, ch_zero_gain_unity, ch_one_dc_filter_bypass, ch_one_use_own_pair;
   logic        ch_one_inputs_shorted, ch_one_test_positive, ch_one_test_negative;
   logic        ch_one_dc_filter_active;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, global_dc_filter_setting;
   logic [1:0]  s_axi_bresp, s_axi_rresp, ch_one_input_select;
   logic [23:0] ch_zero_gain_trim, ch_one_offset_trim;
   logic [9:0]  ch_one_phase_delay;
   int          error_cnt = 0;
   int          cmp_count = 0;

   acr_regs dut_u (
      .mclk                     (mclk),
      .reset                    (reset),
      .clk_en                   (clk_en),
      .s_axi_awaddr             (s_axi_awaddr),
      .s_axi_awvalid            (s_axi_awvalid),
      .s_axi_awready            (s_axi_awready),
      .s_axi_wdata              (s_axi_wdata),
      .s_axi_wstrb              (s_axi_wstrb),
      .s_axi_wvalid             (s_axi_wvalid),
      .s_axi_wready             (s_axi_wready),
      .s_axi_bresp              (s_axi_bresp),
      .s_axi_bvalid             (s_axi_bvalid),
      .s_axi_bready             (s_axi_bready),
      .s_axi_araddr             (s_axi_araddr),
      .s_axi_arvalid            (s_axi_arvalid),
      .s_axi_arready            (s_axi_arready),
      .s_axi_rdata              (s_axi_rdata),
      .s_axi_rresp              (s_axi_rresp),
      .s_axi_rvalid             (s_axi_rvalid),
      .s_axi_rready             (s_axi_rready),
      .ch_zero_gain_trim        (ch_zero_gain_trim),
      .ch_zero_gain_unity       (ch_zero_gain_unity),
      .ch_one_offset_trim       (ch_one_offset_trim),
      .ch_one_phase_delay       (ch_one_phase_delay),
      .ch_one_dc_filter_bypass  (ch_one_dc_filter_bypass),
      .ch_one_input_select      (ch_one_input_select),
      .global_dc_filter_setting (global_dc_filter_setting),
      .ch_one_use_own_pair      (ch_one_use_own_pair),
      .ch_one_inputs_shorted    (ch_one_inputs_shorted),
      .ch_one_test_positive     (ch_one_test_positive),
      .ch_one_test_negative     (ch_one_test_negative),
      .ch_one_dc_filter_active  (ch_one_dc_filter_active)
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tmo(input int n);
      if (n >= 20) begin
         error_cnt++;
         $display("Error at %0t: no answer", $time);
         conclude();
      end
   endtask : tmo

   task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge mclk);
      s_axi_awaddr  <= {22'h0, idx, 2'h0};
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!s_axi_bvalid && n < 20) begin
         @(posedge mclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      tmo(n);
      chk({30'h0, s_axi_bresp}, {30'h0, er});
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge mclk);
      s_axi_araddr  <= {22'h0, idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (!s_axi_rvalid && n < 20) begin
         @(posedge mclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      tmo(n);
      chk(s_axi_rdata, exp);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
      s_axi_rready <= 1'b0;
   endtask : rd
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   initial begin
      static logic [7:0]  it [6] = '{IDX_THRESH_LOW, IDX_CH0_GAIN_HIGH, IDX_CH0_GAIN_LOW,
                                     IDX_CH1_CONFIG, IDX_CH1_OFFSET_HIGH, IDX_CH1_OFFSET_LOW};
      static logic [15:0] rt [6] = '{16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
      static logic [15:0] mt [6] = '{16'hFF0F, 16'hFFFF, 16'hFF00, 16'hFFC7, 16'hFFFF, 16'hFF00};
      logic [1:0]  sel;
      {reset, clk_en} = 2'h3;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      for (int i = 0; i < 6; i++) rd(it[i], {16'h0, rt[i]}, RESP_OKAY);
      chk({31'h0, ch_zero_gain_unity}, 32'h1);
      for (int i = 0; i < 6; i++) begin
         wr(it[i], 32'hFFFF_FFFF, RESP_OKAY);
         rd(it[i], {16'h0, mt[i]}, RESP_OKAY);
      end
      wr(IDX_CH0_GAIN_HIGH, 32'h0000_1234, RESP_OKAY);
      wr(IDX_CH0_GAIN_LOW, 32'h0000_AB5A, RESP_OKAY);
      chk({8'h0, ch_zero_gain_trim}, 32'h0012_34AB);
      chk({31'h0, ch_zero_gain_unity}, 32'h0);
      wr(IDX_CH1_OFFSET_HIGH, 32'h0000_8001, RESP_OKAY);
      wr(IDX_CH1_OFFSET_LOW, 32'h0000_7F33, RESP_OKAY);
      chk({8'h0, ch_one_offset_trim}, 32'h0080_017F);
      wr(IDX_THRESH_LOW, 32'h0000_0005, RESP_OKAY);
      chk({28'h0, global_dc_filter_setting}, 32'h0000_0005);
      for (int s = 0; s < 4; s++) begin
         sel = 2'(s);
         wr(IDX_CH1_CONFIG, {16'h0, 10'h201, 3'h7, sel[0], sel}, RESP_OKAY);
         chk({22'h0, ch_one_phase_delay}, 32'h0000_0201);
         chk({28'h0, ch_one_test_negative, ch_one_test_positive, ch_one_inputs_shorted,
              ch_one_use_own_pair}, 32'h1 << s);
         chk({31'h0, ch_one_dc_filter_active}, {31'h0, !sel[0]});
         chk({29'h0, ch_one_dc_filter_bypass, ch_one_input_select}, {29'h0, sel[0], sel});
      end
      wr(IDX_CH1_CONFIG, 32'h0000_8040, RESP_OKAY);
      chk({31'h0, ch_one_dc_filter_active}, 32'h1);
      wr(IDX_THRESH_LOW, 32'h0000_0000, RESP_OKAY);
      chk({31'h0, ch_one_dc_filter_active}, 32'h0);
      wr(8'h3F, 32'h0000_1111, RESP_SLVERR);
      rd(8'h3F, 32'h0, RESP_SLVERR);
      @(posedge mclk);
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      rd(IDX_CH1_OFFSET_HIGH, 32'h0, RESP_OKAY);
      rd(IDX_CH0_GAIN_HIGH, 32'h0000_8000, RESP_OKAY);
      rd(IDX_CH1_CONFIG, 32'h0, RESP_OKAY);
      rd(IDX_CH1_OFFSET_LOW, 32'h0, RESP_OKAY);
      conclude();
   end
endmodule : acr_regs_tb_top

bind acr_regs acr_regs_sva chk_u (
   .mclk                     (mclk),
   .reset                    (reset),
   .clk_en                   (clk_en),
   .s_axi_awvalid            (s_axi_awvalid),
   .s_axi_awready            (s_axi_awready),
   .s_axi_wvalid             (s_axi_wvalid),
   .s_axi_wready             (s_axi_wready),
   .s_axi_bvalid             (s_axi_bvalid),
   .s_axi_arvalid            (s_axi_arvalid),
   .s_axi_arready            (s_axi_arready),
   .s_axi_rdata              (s_axi_rdata),
   .s_axi_rvalid             (s_axi_rvalid),
   .s_axi_rready             (s_axi_rready),
   .ch_zero_gain_trim        (ch_zero_gain_trim),
   .ch_zero_gain_unity       (ch_zero_gain_unity),
   .ch_one_offset_trim       (ch_one_offset_trim),
   .ch_one_phase_delay       (ch_one_phase_delay),
   .ch_one_dc_filter_bypass  (ch_one_dc_filter_bypass),
   .ch_one_input_select      (ch_one_input_select),
   .global_dc_filter_setting (global_dc_filter_setting),
   .ch_one_use_own_pair      (ch_one_use_own_pair),
   .ch_one_inputs_shorted    (ch_one_inputs_shorted),
   .ch_one_test_positive     (ch_one_test_positive),
   .ch_one_test_negative     (ch_one_test_negative),
   .ch_one_dc_filter_active  (ch_one_dc_filter_active)
);
`default_nettype wire
